// [hw/hpb_pkg.sv]
// Constants and types shared by the host byte port design
package hpb_pkg;
    localparam int          HPB_ADDR_W        = 11;
    localparam int          HPB_DEPTH         = 2048;
    localparam int          HPB_WORD_W        = 16;
    localparam int          HPB_BYTE_W        = 8;
    // Access target codes on {access_select_high, access_select_low}
    localparam logic [1:0]  SEL_CTRL          = 2'h0;
    localparam logic [1:0]  SEL_DATA_INC      = 2'h1;
    localparam logic [1:0]  SEL_ADDR          = 2'h2;
    localparam logic [1:0]  SEL_DATA          = 2'h3;
    // Control register field positions
    localparam int          CTL_HOST_IRQ_BIT  = 1;
    localparam int          CTL_CPU_IRQ_BIT   = 2;
    localparam int          CTL_HOM_BIT       = 3;
    localparam logic [15:0] CTL_RESET         = 16'h0000;
    localparam logic [10:0] ADDR_RESET        = 11'h000;
    // Timing
    localparam int          CLK_PERIOD_NS     = 100;
    localparam int          SAM_BYTE_PERIODS  = 5;
    localparam int          HOM_BYTE_NS       = 50;
    localparam int          HOM_BYTE_CYCLES   = (HOM_BYTE_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                                (HOM_BYTE_NS / CLK_PERIOD_NS);
    localparam int          WAKE_MIN_CYCLES   = 5;
    localparam logic [2:0]  WAKE_CNT_RESET    = 3'h0;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RAM_RD,
        ST_DONE
    } hpb_state_e;
endpackage

// [hw/hpb_buffer_ram.sv]
// Single-access buffer RAM with synchronous read
`timescale 1ns/1ps
module hpb_buffer_ram #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2048,
    parameter int AW    = 11
) (
    // Clock
    input  wire logic             mclk,
    // Access port
    input  wire logic             en,
    input  wire logic             we,
    input  wire logic [AW-1:0]    addr,
    input  wire logic [WIDTH-1:0] wdata,
    output logic      [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge mclk) begin
        if (en && we) begin
            mem[addr] <= wdata;
        end
    end

    // Read data holds until the next enabled read
    always_ff @(posedge mclk) begin
        if (en && !we) begin
            rdata <= mem[addr];
        end
    end
endmodule // hpb_buffer_ram

// [hw/hpb_host_port.sv]
// Host parallel byte port: host pins, control, address, buffer arbitration
//
// Overview of operation
// [RULE_01] A 16-bit word moves as two bytes; byte_half_select marks high or low.
// [RULE_02] A 2k-word single-access buffer RAM is shared by host port and CPU.
// [RULE_03] Host traffic uses its own path to the buffer; the CPU keeps running.
// [RULE_04] The CPU may use the buffer as ordinary data or program memory.
// [RULE_05] Host and CPU reach the control register; host loads the address register.
// [RULE_06] Two select pins pick address, data with or without increment, or control.
// [RULE_07] A host control write can raise an interrupt to the CPU.
// [RULE_08] The device drives a host interrupt output; the host clears it.
// [RULE_09] Shared mode lets both sides use the buffer; host-only mode locks the CPU out.
// [RULE_10] Shared mode resynchronises host strobes; host wins, CPU waits one cycle.
// [RULE_11] Host-only mode serves the host during deep sleep or CPU reset.
// [RULE_12] Two data strobes, read/write select and address strobe serve many host buses.
// [RULE_13] A ready output inserts host wait states automatically; the host obeys it.
// [RULE_14] Shared mode sustains one byte every five device clocks.
// [RULE_15] Host-only mode sustains one byte every 50 ns regardless of device clock; here the pace stays bound by mclk.
// [RULE_16] Host and CPU should coordinate by polling or interrupts to avoid stalls.
// [RULE_17] Deep sleep ends only after a wake pin is held for five cycles.
// [RULE_18] The host interrupt stays set from CPU raise until a host control write clears it.
`timescale 1ns/1ps
module hpb_host_port
    import hpb_pkg::*;
(
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // Host pins
    input  wire logic [HPB_BYTE_W-1:0] host_data_in,
    output logic      [HPB_BYTE_W-1:0] host_data_out,
    output logic                       host_data_oe,
    input  wire logic                  access_select_high,
    input  wire logic                  access_select_low,
    input  wire logic                  byte_half_select,
    input  wire logic                  host_read_write,
    input  wire logic                  data_strobe_one_n,
    input  wire logic                  data_strobe_two_n,
    input  wire logic                  addr_strobe_n,
    output logic                       host_wait_ready,
    output logic                       host_interrupt_out_n,
    // CPU buffer port
    input  wire logic                  cpu_req,
    input  wire logic                  cpu_we,
    input  wire logic [HPB_ADDR_W-1:0] cpu_addr,
    input  wire logic [HPB_WORD_W-1:0] cpu_wdata,
    output logic      [HPB_WORD_W-1:0] cpu_rdata,
    output logic                       cpu_ack,
    // CPU control register port
    input  wire logic                  cpu_ctl_we,
    input  wire logic [HPB_WORD_W-1:0] cpu_ctl_wdata,
    output logic      [HPB_WORD_W-1:0] cpu_ctl_rdata,
    output logic                       cpu_host_irq,
    // Power state
    input  wire logic                  cpu_in_reset,
    input  wire logic                  sleep_req,
    input  wire logic                  ext_wake_n,
    output logic                       deep_sleep
);
    import hpb_pkg::*;

    // Pin synchronisers: stage one feeds stage two only
    logic [15:0] pin_s1_q;
    logic [15:0] pin_s2_q;
    logic       strobe_raw;
    logic       strobe_d1_q;
    logic       strobe_s;
    logic       as_s;
    logic       as_d1_q;
    logic       wake_s;
    logic [7:0] host_byte;

    assign strobe_raw = data_strobe_one_n ^ data_strobe_two_n; // RULE_12

    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_s1_q <= 16'h0000;
            pin_s2_q <= 16'h0000;
        end else begin
            // Selects and data pass the same two flops, so they line up with the strobe
            pin_s1_q <= {access_select_high, access_select_low, byte_half_select,
                         host_read_write, host_data_in, ~ext_wake_n, ~addr_strobe_n,
                         1'b0, strobe_raw}; // RULE_10
            pin_s2_q <= pin_s1_q;
        end
    end
    assign strobe_s = pin_s2_q[0];
    assign as_s     = pin_s2_q[2];
    assign wake_s   = pin_s2_q[3];
    assign host_byte = pin_s2_q[11:4];

    always_ff @(posedge mclk) begin
        if (rst) begin
            strobe_d1_q <= 1'b0;
            as_d1_q     <= 1'b0;
        end else begin
            strobe_d1_q <= strobe_s;
            as_d1_q     <= as_s;
        end
    end

    logic strobe_start;
    logic as_start;
    assign strobe_start = strobe_s && !strobe_d1_q;
    assign as_start     = as_s && !as_d1_q;

    // Control bits are quiet by the time the synced strobe is seen; an address
    // strobe latches them early for hosts with a multiplexed bus
    logic [3:0] ctl_lat_q;
    logic       as_held_q;
    logic [3:0] ctl_pins;
    logic [3:0] ctl_use;
    assign ctl_pins = pin_s2_q[15:12];

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctl_lat_q <= 4'h0;
            as_held_q <= 1'b0;
        end else if (as_start) begin
            ctl_lat_q <= ctl_pins; // RULE_12
            as_held_q <= 1'b1;
        end else if (strobe_start) begin
            as_held_q <= 1'b0;
        end
    end
    assign ctl_use = as_held_q ? ctl_lat_q : ctl_pins;

    logic [1:0] sel;
    logic       second_byte;
    logic       host_rd;
    assign sel         = ctl_use[3:2];
    assign second_byte = ctl_use[1];
    assign host_rd     = ctl_use[0];

    function automatic logic is_data(input logic [1:0] s);
        is_data = (s == SEL_DATA) || (s == SEL_DATA_INC);
    endfunction

    // Host access engine
    hpb_state_e          state_q;
    logic [1:0]          acc_sel_q;
    logic                acc_second_q;
    logic [7:0]          hi_byte_q;
    logic [15:0]         rd_word_q;
    logic [10:0]         addr_q;
    logic [15:0]         ctl_q;
    logic                host_ram_en;
    logic                host_ram_we;
    logic                host_ctl_wr;
    logic                cpu_irq_q;
    logic [15:0]         ram_rdata;
    logic [15:0]         ctl_view;

    assign host_ram_en = strobe_start && is_data(sel) && (!host_rd ? second_byte : !second_byte);
    assign host_ram_we = host_ram_en && !host_rd; // RULE_01
    assign host_ctl_wr = strobe_start && (sel == SEL_CTRL) && !host_rd && second_byte;

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q      <= ST_IDLE;
            acc_sel_q    <= SEL_CTRL;
            acc_second_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (strobe_start) begin
                        acc_sel_q    <= sel;
                        acc_second_q <= second_byte;
                        state_q      <= (host_ram_en && host_rd) ? ST_RAM_RD : ST_DONE;
                    end
                end
                ST_RAM_RD: state_q <= ST_DONE;
                ST_DONE: begin
                    if (!strobe_s) begin
                        state_q <= ST_IDLE; // RULE_14
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Ready is low from the synced strobe until the byte is served
    assign host_wait_ready = !(strobe_s && state_q != ST_DONE); // RULE_13

    // First byte on write is held until its partner arrives
    always_ff @(posedge mclk) begin
        if (rst) begin
            hi_byte_q <= 8'h00;
        end else if (strobe_start && !host_rd && !second_byte) begin
            hi_byte_q <= host_byte; // RULE_01
        end
    end

    // Address register: loaded by host, post-incremented after each auto-increment data word
    always_ff @(posedge mclk) begin
        if (rst) begin
            addr_q <= ADDR_RESET;
        end else if (strobe_start && sel == SEL_ADDR && !host_rd && second_byte) begin
            addr_q <= {hi_byte_q[2:0], host_byte}; // RULE_05
        end else if (strobe_start && sel == SEL_DATA_INC && second_byte) begin
            addr_q <= addr_q + 11'h001; // RULE_06
        end
    end

    // Control register; CPU set of the host interrupt wins over a host clear
    logic cpu_set_host_interrupt_out;
    logic host_clr_host_interrupt_out;
    assign cpu_set_host_interrupt_out  = cpu_ctl_we && cpu_ctl_wdata[CTL_HOST_IRQ_BIT];
    assign host_clr_host_interrupt_out = host_ctl_wr && hi_byte_q[0] == 1'b0 && host_byte[CTL_HOST_IRQ_BIT];

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctl_q <= CTL_RESET;
        end else begin
            if (cpu_set_host_interrupt_out) begin
                ctl_q[CTL_HOST_IRQ_BIT] <= 1'b1; // RULE_08
            end else if (host_clr_host_interrupt_out) begin
                ctl_q[CTL_HOST_IRQ_BIT] <= 1'b0; // RULE_18
            end
            if (host_ctl_wr) begin
                ctl_q[CTL_HOM_BIT] <= host_byte[CTL_HOM_BIT]; // RULE_09
            end else if (cpu_ctl_we) begin
                ctl_q[CTL_HOM_BIT] <= cpu_ctl_wdata[CTL_HOM_BIT];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cpu_irq_q <= 1'b0;
        end else begin
            cpu_irq_q <= host_ctl_wr && host_byte[CTL_CPU_IRQ_BIT]; // RULE_07
        end
    end
    assign cpu_host_irq         = cpu_irq_q;
    assign host_interrupt_out_n = !ctl_q[CTL_HOST_IRQ_BIT];
    assign ctl_view             = ctl_q;
    assign cpu_ctl_rdata        = ctl_view; // RULE_05

    // Buffer arbitration: host first, CPU shut out in host-only mode or when down
    logic host_only;
    logic cpu_ram_go;
    logic [10:0] ram_addr;
    logic        ram_en;
    logic        ram_we;
    logic [15:0] ram_wdata;
    logic        cpu_rd_q;

    // Host-only pace is still bound by mclk: the port has no clock of its own
    assign host_only  = ctl_q[CTL_HOM_BIT]; // RULE_15
    assign cpu_ram_go = cpu_req && !host_ram_en && !host_only && !deep_sleep && !cpu_in_reset;
    assign cpu_ack    = cpu_ram_go; // RULE_10
    assign ram_en     = host_ram_en || cpu_ram_go; // RULE_03
    assign ram_we     = host_ram_en ? host_ram_we : cpu_we; // RULE_04
    assign ram_addr   = host_ram_en ? addr_q : cpu_addr; // RULE_11
    assign ram_wdata  = host_ram_en ? {hi_byte_q, host_byte} : cpu_wdata;

    hpb_buffer_ram #(
        .WIDTH (HPB_WORD_W),
        .DEPTH (HPB_DEPTH),
        .AW    (HPB_ADDR_W)
    ) u_ram (
        .mclk  (mclk),
        .en    (ram_en),
        .we    (ram_we),
        .addr  (ram_addr),
        .wdata (ram_wdata),
        .rdata (ram_rdata)
    ); // RULE_02

    always_ff @(posedge mclk) begin
        if (rst) begin
            cpu_rd_q <= 1'b0;
        end else begin
            cpu_rd_q <= cpu_ram_go && !cpu_we;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cpu_rdata <= 16'h0000;
        end else if (cpu_rd_q) begin
            cpu_rdata <= ram_rdata;
        end
    end

    // Host read word: captured on the first byte, low half served on the second
    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_word_q <= 16'h0000;
        end else if (state_q == ST_RAM_RD) begin
            rd_word_q <= ram_rdata;
        end else if (strobe_start && host_rd && !second_byte && sel == SEL_ADDR) begin
            rd_word_q <= {5'h00, addr_q};
        end else if (strobe_start && host_rd && !second_byte && sel == SEL_CTRL) begin
            rd_word_q <= ctl_view;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            host_data_out <= 8'h00;
            host_data_oe  <= 1'b0;
        end else begin
            host_data_out <= acc_second_q ? rd_word_q[7:0] : rd_word_q[15:8]; // RULE_01
            host_data_oe  <= strobe_s && host_rd && state_q == ST_DONE;
        end
    end

    // Deep sleep: left only after wake held five synced cycles
    logic [2:0] wake_cnt_q;
    logic       sleep_q;
    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_cnt_q <= WAKE_CNT_RESET;
        end else if (!sleep_q || !wake_s) begin
            wake_cnt_q <= WAKE_CNT_RESET;
        end else if (wake_cnt_q < 3'(WAKE_MIN_CYCLES)) begin
            wake_cnt_q <= wake_cnt_q + 3'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sleep_q <= 1'b0;
        end else if (sleep_q && wake_s && wake_cnt_q == 3'(WAKE_MIN_CYCLES - 1)) begin
            sleep_q <= 1'b0; // RULE_17
        end else if (sleep_req) begin
            sleep_q <= 1'b1;
        end
    end
    assign deep_sleep = sleep_q;

    // Checks
    sequence s_host_ctl_set;
        host_ctl_wr && host_byte[CTL_CPU_IRQ_BIT];
    endsequence

    property p_host_wins;
        @(posedge mclk) disable iff (rst) (host_ram_en && cpu_req) |-> !cpu_ack;
    endproperty
    a_host_wins: assert property (p_host_wins) else $error("cpu granted over host"); // RULE_10

    property p_hom_lock;
        @(posedge mclk) disable iff (rst) host_only |-> !cpu_ack;
    endproperty
    a_hom_lock: assert property (p_hom_lock) else $error("cpu used buffer in host-only"); // RULE_09

    property p_cpu_free;
        @(posedge mclk) disable iff (rst)
            (cpu_req && !host_ram_en && !host_only && !deep_sleep && !cpu_in_reset) |-> cpu_ack;
    endproperty
    a_cpu_free: assert property (p_cpu_free) else $error("cpu stalled without host"); // RULE_03

    property p_host_interrupt_out_set;
        @(posedge mclk) disable iff (rst) cpu_set_host_interrupt_out |=> !host_interrupt_out_n;
    endproperty
    a_host_interrupt_out_set: assert property (p_host_interrupt_out_set) else $error("host interrupt not raised"); // RULE_08

    property p_host_interrupt_out_hold;
        @(posedge mclk) disable iff (rst)
            (!host_interrupt_out_n && !host_clr_host_interrupt_out) |=> !host_interrupt_out_n;
    endproperty
    a_host_interrupt_out_hold: assert property (p_host_interrupt_out_hold) else $error("host interrupt dropped"); // RULE_18

    property p_cpu_irq;
        @(posedge mclk) disable iff (rst) s_host_ctl_set |=> cpu_host_irq ##1 !cpu_host_irq;
    endproperty
    a_cpu_irq: assert property (p_cpu_irq) else $error("cpu interrupt pulse wrong"); // RULE_07

    property p_byte_rate;
        @(posedge mclk) disable iff (rst) strobe_start |-> ##[1:2] (state_q == ST_DONE);
    endproperty
    a_byte_rate: assert property (p_byte_rate) else $error("byte not served in time"); // RULE_14

    property p_autoinc;
        @(posedge mclk) disable iff (rst)
            (strobe_start && sel == SEL_DATA_INC && second_byte) |=>
            addr_q == $past(addr_q) + 11'h001;
    endproperty
    a_autoinc: assert property (p_autoinc) else $error("address not incremented"); // RULE_06

    property p_wake;
        @(posedge mclk) disable iff (rst) (deep_sleep && wake_s) [*5] |=> !deep_sleep;
    endproperty
    a_wake: assert property (p_wake) else $error("deep sleep not left"); // RULE_17

    property p_pair_write;
        @(posedge mclk) disable iff (rst)
            host_ram_we |-> (ram_wdata == {hi_byte_q, host_byte} && ram_addr == addr_q);
    endproperty
    a_pair_write: assert property (p_pair_write) else $error("word pairing wrong"); // RULE_01
endmodule // hpb_host_port

// [bench/hpb_host_model.sv]
// Behavioural host processor driving the byte port pins
`timescale 1ns/1ps
module hpb_host_model
    import hpb_pkg::*;
(
    // Clock
    input  wire logic                  mclk,
    // Host pins
    output logic      [HPB_BYTE_W-1:0] host_data_in,
    input  wire logic [HPB_BYTE_W-1:0] host_data_out,
    input  wire logic                  host_data_oe,
    output logic                       access_select_high,
    output logic                       access_select_low,
    output logic                       byte_half_select,
    output logic                       host_read_write,
    output logic                       data_strobe_one_n,
    output logic                       data_strobe_two_n,
    output logic                       addr_strobe_n,
    input  wire logic                  host_wait_ready
);
    logic saw_wait;
    logic timed_out;

    initial begin
        host_data_in       = 8'h00;
        access_select_high = 1'b0;
        access_select_low  = 1'b0;
        byte_half_select   = 1'b0;
        host_read_write    = 1'b1;
        data_strobe_one_n  = 1'b1;
        data_strobe_two_n  = 1'b1;
        // Select pins stay steady through each strobe, so no address phase is needed
        addr_strobe_n      = 1'b1;
        saw_wait           = 1'b0;
        timed_out          = 1'b0;
    end

    task automatic put_byte(input logic [1:0] sel, input logic half, input logic rd,
                            input logic [7:0] wd, output logic [7:0] got);
        int n;
        @(posedge mclk);
        {access_select_high, access_select_low} <= sel;
        byte_half_select  <= half;
        host_read_write   <= rd;
        host_data_in      <= wd;
        // Writes use the first strobe, reads the second
        data_strobe_one_n <= rd;
        data_strobe_two_n <= ~rd;
        saw_wait = 1'b0;
        for (n = 0; n < 40; n++) begin
            @(negedge mclk);
            if (host_wait_ready === 1'b0)
                saw_wait = 1'b1;
            else if (saw_wait)
                break;
        end
        if (n == 40)
            timed_out = 1'b1;
        @(negedge mclk);
        got = (host_data_oe === 1'b1) ? host_data_out : 8'hxx;
        @(posedge mclk);
        data_strobe_one_n <= 1'b1;
        data_strobe_two_n <= 1'b1;
        // A released bus must not keep looking like the last byte
        host_data_in      <= ~wd;
        repeat (SAM_BYTE_PERIODS + 2) @(posedge mclk);
    endtask

    task automatic xfer_word(input logic [1:0] sel, input logic rd, input logic [15:0] wd,
                             output logic [15:0] got);
        put_byte(sel, 1'b0, rd, wd[15:8], got[15:8]);
        put_byte(sel, 1'b1, rd, wd[7:0], got[7:0]);
    endtask
endmodule // hpb_host_model

// [bench/tb.sv]
// Self-checking bench for the host byte port
`timescale 1ns/1ps
module tb;
    import hpb_pkg::*;
    // Clock, reset and host pins
    logic        mclk;
    logic        rst;
    logic [7:0]  host_data_in;
    logic [7:0]  host_data_out;
    logic        host_data_oe;
    logic        access_select_high;
    logic        access_select_low;
    logic        byte_half_select;
    logic        host_read_write;
    logic        data_strobe_one_n;
    logic        data_strobe_two_n;
    logic        addr_strobe_n;
    logic        host_wait_ready;
    logic        host_interrupt_out_n;
    // CPU side and power
    logic        cpu_req;
    logic        cpu_we;
    logic [10:0] cpu_addr;
    logic [15:0] cpu_wdata;
    logic [15:0] cpu_rdata;
    logic        cpu_ack;
    logic        cpu_ctl_we;
    logic [15:0] cpu_ctl_wdata;
    logic [15:0] cpu_ctl_rdata;
    logic        cpu_host_irq;
    logic        cpu_in_reset;
    logic        sleep_req;
    logic        ext_wake_n;
    logic        deep_sleep;
    int          num_errors;
    int          check_count;
    int          irq_count;
    int          refusals;
    logic [15:0] got;

    hpb_host_port u_dut (.mclk, .rst, .host_data_in, .host_data_out, .host_data_oe,
        .access_select_high, .access_select_low, .byte_half_select, .host_read_write,
        .data_strobe_one_n, .data_strobe_two_n, .addr_strobe_n, .host_wait_ready,
        .host_interrupt_out_n, .cpu_req, .cpu_we, .cpu_addr, .cpu_wdata, .cpu_rdata,
        .cpu_ack, .cpu_ctl_we, .cpu_ctl_wdata, .cpu_ctl_rdata, .cpu_host_irq,
        .cpu_in_reset, .sleep_req, .ext_wake_n, .deep_sleep);

    hpb_host_model u_host (.mclk, .host_data_in, .host_data_out, .host_data_oe,
        .access_select_high, .access_select_low, .byte_half_select, .host_read_write,
        .data_strobe_one_n, .data_strobe_two_n, .addr_strobe_n, .host_wait_ready);

    always #50 mclk = ~mclk;

    always @(negedge mclk) begin
        if (cpu_host_irq === 1'b1)
            irq_count++;
        if (cpu_req === 1'b1 && cpu_ack === 1'b0)
            refusals++;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic host(input logic [1:0] sel, input logic rd, input logic [15:0] wd);
        u_host.xfer_word(sel, rd, wd, got);
        if (u_host.timed_out === 1'b1) begin
            num_errors++;
            complete_run();
        end
    endtask

    task automatic cpu(input logic we, input logic [10:0] a, input logic [15:0] wd);
        int n;
        @(posedge mclk);
        cpu_req   <= 1'b1;
        cpu_we    <= we;
        cpu_addr  <= a;
        cpu_wdata <= wd;
        for (n = 0; n < 20; n++) begin
            @(negedge mclk);
            if (cpu_ack === 1'b1)
                break;
        end
        @(posedge mclk);
        cpu_req <= 1'b0;
        if (n == 20) begin
            num_errors++;
            complete_run();
        end
        repeat (2) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic t_reset();
        @(negedge mclk);
        check({15'h0, host_interrupt_out_n}, 16'h0001);
        check({15'h0, host_wait_ready}, 16'h0001);
        check({15'h0, host_data_oe}, 16'h0000);
        check({15'h0, deep_sleep}, 16'h0000);
        check(cpu_ctl_rdata, CTL_RESET);
        cpu(1'b1, ADDR_RESET, 16'h5aa5);
        // Host reads only after the CPU has finished
        host(SEL_DATA, 1'b1, 16'h0000);
        check(got, 16'h5aa5);
    endtask

    task automatic t_buffer();
        // Upper first-byte bits fall outside the address and must be dropped
        host(SEL_ADDR, 1'b0, 16'hf7fe);
        host(SEL_DATA_INC, 1'b0, 16'h1234);
        host(SEL_DATA_INC, 1'b0, 16'habcd);
        cpu(1'b0, 11'h7fe, 16'h0000);
        check(cpu_rdata, 16'h1234);
        cpu(1'b0, 11'h7ff, 16'h0000);
        check(cpu_rdata, 16'habcd);
        host(SEL_ADDR, 1'b0, 16'h07fe);
        host(SEL_DATA, 1'b1, 16'h0000);
        check(got, 16'h1234);
        host(SEL_DATA_INC, 1'b1, 16'h0000);
        check(got, 16'h1234);
        host(SEL_DATA_INC, 1'b1, 16'h0000);
        check(got, 16'habcd);
    endtask

    task automatic t_irq();
        @(posedge mclk);
        cpu_ctl_we    <= 1'b1;
        cpu_ctl_wdata <= 16'h0002;
        @(posedge mclk);
        cpu_ctl_we    <= 1'b0;
        repeat (2) @(negedge mclk);
        check({15'h0, host_interrupt_out_n}, 16'h0000);
        host(SEL_CTRL, 1'b1, 16'h0000);
        check(got & 16'h0002, 16'h0002);
        irq_count = 0;
        host(SEL_CTRL, 1'b0, 16'h0102);
        check({15'h0, host_interrupt_out_n}, 16'h0000);
        host(SEL_CTRL, 1'b0, 16'h0004);
        check(irq_count[15:0], 16'h0001);
        host(SEL_CTRL, 1'b0, 16'h0002);
        check({15'h0, host_interrupt_out_n}, 16'h0001);
        check(irq_count[15:0], 16'h0001);
    endtask

    task automatic t_conflict();
        @(posedge mclk);
        cpu_req  <= 1'b1;
        cpu_we   <= 1'b0;
        cpu_addr <= 11'h7fe;
        refusals = 0;
        // A first-byte read is what touches the buffer, so it meets the CPU head on
        u_host.put_byte(SEL_DATA, 1'b0, 1'b1, 8'h00, got[15:8]);
        cpu_req  <= 1'b0;
        check(refusals[15:0], 16'h0001);
        check({8'h00, got[15:8]}, 16'h005a);
    endtask

    task automatic t_host_only();
        host(SEL_CTRL, 1'b0, 16'h0008);
        check(cpu_ctl_rdata & 16'h0008, 16'h0008);
        // CPU stays out of reset here, so only the mode can refuse it
        @(posedge mclk);
        cpu_req      <= 1'b1;
        refusals = 0;
        repeat (5) @(posedge mclk);
        cpu_req      <= 1'b0;
        cpu_in_reset <= 1'b1;
        check(refusals[15:0], 16'h0005);
        host(SEL_ADDR, 1'b0, 16'h0010);
        host(SEL_DATA, 1'b0, 16'h9e37);
        host(SEL_DATA, 1'b1, 16'h0000);
        check(got, 16'h9e37);
        host(SEL_ADDR, 1'b1, 16'h0000);
        check(got, 16'h0010);
        host(SEL_CTRL, 1'b0, 16'h0000);
        @(posedge mclk);
        cpu_in_reset <= 1'b0;
        cpu(1'b0, 11'h010, 16'h0000);
        check(cpu_rdata, 16'h9e37);
    endtask

    task automatic t_sleep();
        int n;
        @(posedge mclk);
        sleep_req <= 1'b1;
        @(posedge mclk);
        sleep_req <= 1'b0;
        repeat (2) @(negedge mclk);
        check({15'h0, deep_sleep}, 16'h0001);
        @(posedge mclk);
        // Too short a wake pulse must leave the device asleep
        ext_wake_n <= 1'b0;
        repeat (4) @(posedge mclk);
        ext_wake_n <= 1'b1;
        repeat (8) @(negedge mclk);
        check({15'h0, deep_sleep}, 16'h0001);
        @(posedge mclk);
        ext_wake_n <= 1'b0;
        for (n = 0; n < 20 && deep_sleep !== 1'b0; n++)
            @(negedge mclk);
        @(posedge mclk);
        ext_wake_n <= 1'b1;
        check({15'h0, (n >= 5 && n < 20)}, 16'h0001);
    endtask

    initial begin
        mclk          = 1'b0;
        rst           = 1'b1;
        cpu_req       = 1'b0;
        cpu_we        = 1'b0;
        cpu_addr      = 11'h000;
        cpu_wdata     = 16'h0000;
        cpu_ctl_we    = 1'b0;
        cpu_ctl_wdata = 16'h0000;
        cpu_in_reset  = 1'b0;
        sleep_req     = 1'b0;
        ext_wake_n    = 1'b1;
        num_errors    = 0;
        check_count   = 0;
        irq_count     = 0;
        refusals      = 0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        t_reset();
        t_buffer();
        t_irq();
        t_conflict();
        t_host_only();
        t_sleep();
        complete_run();
    end

    initial begin
        #2000000;
        num_errors++;
        complete_run();
    end
endmodule // tb
